// File: logic/link_fault_signaling_rs.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module link_fault_signaling_rs
  import lfs_pkg::*;
#(
  parameter bit LF_GEN_EN = 1'b1,
  parameter int unsigned BUF_DEPTH = 2
)
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // Register port
  input wire logic [ADDR_W-1:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [31:0] O_REG_RDATA,
  // Receive columns from the PCS
  input wire col_t I_RX_COL,
  input wire logic I_RX_VALID,
  // Transmit columns from the MAC
  input wire col_t I_TX_COL,
  input wire logic I_TX_VALID,
  output logic O_TX_READY,
  // Transmit columns toward the PCS
  output col_t O_PCS_COL,
  output logic O_PCS_VALID,
  input wire logic I_PCS_READY,
  // Fault signaling outputs
  output logic O_LOCAL_FAULT,
  output logic O_REMOTE_FAULT,
  output logic O_UNIDIR_EN,
  output logic O_FAULT_GEN_EN
);

  initial
  begin
    if (BUF_DEPTH != 2)
      $error("link_fault_signaling_rs: BUF_DEPTH must be 2");
  end

  // ****************************************
  // Register decode
  // ****************************************
  logic [1:0] cfg_q;
  logic [31:0] rdata_q;
  logic local_q;
  logic remote_q;
  fault_t link_fault_q;
  lf_state_t state_q;

  wire cfg_sel = (I_REG_ADDR == CFG_ADDR);
  wire stat_sel = (I_REG_ADDR == STAT_ADDR);
  wire cfg_wr = I_REG_WR && cfg_sel;
  wire [31:0] cfg_word = {30'h0, cfg_q};
  wire [31:0] stat_word = {26'h0, link_fault_q, state_q, remote_q, local_q};
  wire [31:0] rd_mux = cfg_sel ? cfg_word : (stat_sel ? stat_word : 32'h0);

  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      cfg_q <= CFG_RESET;
    else if (cfg_wr)
      cfg_q <= I_REG_WDATA[1:0];
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      rdata_q <= 32'h0;
    else
      rdata_q <= I_REG_RD ? rd_mux : 32'h0;
  end

  assign O_REG_RDATA = rdata_q;

  // ****************************************
  // Receive column inspection
  // ****************************************
  // Lane 0 of each half holds the sequence char, lane 3 the code
  function automatic fault_t half_code(input logic [31:0] d, input logic [3:0] c);
    fault_t r;
    r = FLT_OK;
    if (c == SEQ_CTRL && d[7:0] == SEQ_CHAR && d[23:8] == 16'h0000)
    begin
      if (d[31:24] == CODE_LOCAL)
        r = FLT_LOCAL;
      else if (d[31:24] == CODE_REMOTE)
        r = FLT_REMOTE;
    end
    return r;
  endfunction : half_code

  wire fault_t code_lo = half_code(I_RX_COL.data[31:0], I_RX_COL.ctrl[3:0]);
  wire fault_t code_hi = half_code(I_RX_COL.data[63:32], I_RX_COL.ctrl[7:4]);
  wire fault_t seq_type = (code_lo != FLT_OK) ? code_lo : code_hi;
  wire seq_hit = I_RX_VALID && (seq_type != FLT_OK);
  wire good_col = I_RX_VALID && (seq_type == FLT_OK);

  // ****************************************
  // Link fault state machine
  // ****************************************
  logic [7:0] col_cnt_q;
  logic [7:0] col_cnt_d;
  logic [1:0] seq_cnt_q;
  logic [1:0] seq_cnt_d;
  fault_t last_seq_q;
  fault_t last_seq_d;
  fault_t link_fault_d;
  lf_state_t state_d;

  wire win_end = good_col && (col_cnt_q == FAULT_WIN - 8'h01);
  wire same_seq = (seq_type == last_seq_q) && (col_cnt_q < FAULT_WIN);

  always_comb
  begin
    state_d = state_q;
    col_cnt_d = col_cnt_q;
    seq_cnt_d = seq_cnt_q;
    last_seq_d = last_seq_q;
    link_fault_d = link_fault_q;
    if (good_col && col_cnt_q != FAULT_WIN)
      col_cnt_d = col_cnt_q + 8'h01;
    if (win_end)
    begin
      state_d = ST_COUNT;
      seq_cnt_d = 2'h0;
      last_seq_d = FLT_OK;
      link_fault_d = FLT_OK;
    end
    else if (seq_hit)
    begin
      col_cnt_d = 8'h00;
      case (state_q)
        ST_COUNT:
        begin
          if (same_seq && seq_cnt_q == SEQ_LAST)
          begin
            state_d = ST_FAULT;
            link_fault_d = seq_type;
            seq_cnt_d = 2'h0;
          end
          else if (same_seq)
            seq_cnt_d = seq_cnt_q + 2'h1;
          else
          begin
            last_seq_d = seq_type;
            seq_cnt_d = 2'h1;
          end
        end
        ST_FAULT:
        begin
          if (seq_type != link_fault_q)
          begin
            state_d = ST_COUNT;
            last_seq_d = seq_type;
            seq_cnt_d = 2'h1;
          end
        end
        default:
        begin
          state_d = ST_COUNT;
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_q <= ST_COUNT;
      col_cnt_q <= 8'h00;
      seq_cnt_q <= 2'h0;
      last_seq_q <= FLT_OK;
      link_fault_q <= FLT_OK;
    end
    else
    begin
      state_q <= state_d;
      col_cnt_q <= col_cnt_d;
      seq_cnt_q <= seq_cnt_d;
      last_seq_q <= last_seq_d;
      link_fault_q <= link_fault_d;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  wire set_local = seq_hit && (seq_type == FLT_LOCAL);
  wire set_remote = seq_hit && (seq_type == FLT_REMOTE);

  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      local_q <= 1'b0;
      remote_q <= 1'b0;
    end
    else
    begin
      local_q <= set_local || (local_q && !win_end);
      remote_q <= set_remote || (remote_q && !win_end);
    end
  end

  // ****************************************
  // Transmit column selection
  // ****************************************
  wire gen_on = cfg_q[CFG_EN_BIT];
  wire bidir = (cfg_q == MODE_BIDIR);
  wire unidir = (cfg_q == MODE_UNIDIR);
  wire tx_is_idle = (I_TX_COL == IDLE_COL);
  wire send_rf_bidir = bidir && (link_fault_q == FLT_LOCAL);
  wire send_idle = bidir && (link_fault_q == FLT_REMOTE);
  wire send_rf_gap = unidir && (link_fault_q == FLT_LOCAL) && tx_is_idle;
  wire col_t mux_col = (send_rf_bidir || send_rf_gap) ? REMOTE_COL :
                       (send_idle ? IDLE_COL : I_TX_COL);

  lfs_skid_fifo #(
    .WIDTH($bits(col_t)),
    .DEPTH(BUF_DEPTH)
  ) u_tx_buf (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_data(mux_col),
    .i_valid(I_TX_VALID),
    .o_ready(O_TX_READY),
    .o_data(O_PCS_COL),
    .o_valid(O_PCS_VALID),
    .i_ready(I_PCS_READY)
  );

  // ****************************************
  // Fault signaling outputs
  // ****************************************
  assign O_LOCAL_FAULT = LF_GEN_EN && local_q;
  assign O_REMOTE_FAULT = LF_GEN_EN && remote_q;
  assign O_UNIDIR_EN = LF_GEN_EN && cfg_q[CFG_UNIDIR_BIT];
  assign O_FAULT_GEN_EN = LF_GEN_EN && gen_on;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);

  sequence s_cfg_write;
    cfg_wr;
  endsequence

  sequence s_empty_push;
    I_TX_VALID && !O_PCS_VALID;
  endsequence

  sequence s_window_end;
    good_col && col_cnt_q == FAULT_WIN - 8'h01;
  endsequence

  chk_gen_off_reset: assert property (
    $rose(cfg_q[CFG_EN_BIT]) |-> $past(cfg_wr) && $past(I_REG_WDATA[0]))
    else $error("fault generation enabled without a write");

  chk_bidir_remote: assert property (
    s_empty_push ##0 send_rf_bidir |=> O_PCS_VALID && O_PCS_COL == REMOTE_COL)
    else $error("local fault did not send remote fault column");

  chk_bidir_idle: assert property (
    s_empty_push ##0 (bidir && link_fault_q == FLT_REMOTE) |=> O_PCS_COL == IDLE_COL)
    else $error("remote fault did not send idle column");

  chk_unidir_frame: assert property (
    s_empty_push ##0 (unidir && !tx_is_idle) |=> O_PCS_COL == $past(I_TX_COL))
    else $error("unidirectional mode altered frame column");

  chk_flag_set: assert property (
    I_RX_VALID && code_lo == FLT_LOCAL |=> local_q ##1 (local_q || $past(win_end)))
    else $error("local fault flag not raised");

  chk_flag_clear: assert property (
    s_window_end |=> !local_q && !remote_q)
    else $error("fault flags not cleared after 128 valid columns");

  chk_four_sequences: assert property (
    $rose(state_q == ST_FAULT) |-> $past(seq_cnt_q) == SEQ_LAST && $past(seq_hit))
    else $error("fault state entered without four sequences");

  chk_ok_window: assert property (
    s_window_end |=> link_fault_q == FLT_OK && state_q == ST_COUNT)
    else $error("link fault not restored after 128 columns");

  chk_flags_on_rx: assert property (
    $rose(remote_q) |-> $past(I_RX_VALID) && $past(seq_type) == FLT_REMOTE)
    else $error("remote flag rose without a received column");

  chk_unidir_out: assert property (
    s_cfg_write |=> O_UNIDIR_EN == (LF_GEN_EN && $past(I_REG_WDATA[1])))
    else $error("one-way output does not follow config");

  chk_read_next: assert property (
    I_REG_RD && cfg_sel |=> O_REG_RDATA[0] == O_FAULT_GEN_EN || !LF_GEN_EN)
    else $error("config read disagrees with generation output");

endmodule : link_fault_signaling_rs

`default_nettype wire

// File: logic/lfs_pkg.sv
package lfs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W = 16;
  localparam logic [15:0] CFG_INDEX = 16'h0405;
  localparam logic [15:0] STAT_INDEX = 16'h0406;
  localparam logic [15:0] CFG_ADDR = {CFG_INDEX[13:0], 2'b00};
  localparam logic [15:0] STAT_ADDR = {STAT_INDEX[13:0], 2'b00};
  localparam int unsigned CFG_EN_BIT = 0;
  localparam int unsigned CFG_UNIDIR_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [1:0] MODE_BIDIR = 2'h1;
  localparam logic [1:0] MODE_UNIDIR = 2'h3;
  localparam int unsigned STAT_LOCAL_BIT = 0;
  localparam int unsigned STAT_REMOTE_BIT = 1;
  localparam int unsigned STAT_STATE_LSB = 2;

  // ****************************************
  // Column coding
  // ****************************************
  localparam logic [7:0] SEQ_CHAR = 8'h9c;
  localparam logic [7:0] IDLE_CHAR = 8'h07;
  localparam logic [7:0] CODE_LOCAL = 8'h01;
  localparam logic [7:0] CODE_REMOTE = 8'h02;
  localparam logic [3:0] SEQ_CTRL = 4'h1;
  localparam logic [7:0] IDLE_CTRL = 8'hff;

  // ****************************************
  // Column counts
  // ****************************************
  localparam logic [7:0] FAULT_WIN = 8'h80;
  localparam logic [1:0] SEQ_LAST = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] ctrl;
  } col_t;

  typedef enum logic [1:0] {
    FLT_OK = 2'h0,
    FLT_LOCAL = 2'h1,
    FLT_REMOTE = 2'h2
  } fault_t;

  typedef enum logic [1:0] {
    ST_COUNT = 2'b01,
    ST_FAULT = 2'b10
  } lf_state_t;

  localparam col_t IDLE_COL = '{data: {8{IDLE_CHAR}}, ctrl: IDLE_CTRL};
  localparam col_t REMOTE_COL = '{
    data: {2{CODE_REMOTE, 16'h0000, SEQ_CHAR}},
    ctrl: {2{SEQ_CTRL}}
  };

endpackage : lfs_pkg

// File: logic/lfs_skid_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module lfs_skid_fifo
  import lfs_pkg::*;
#(
  parameter int unsigned WIDTH = 72,
  parameter int unsigned DEPTH = 2
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Filling side
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  // Draining side
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("lfs_skid_fifo: DEPTH must be a power of two, at least 2");
  end

  // ****************************************
  // Storage and pointers
  // ****************************************
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;

  assign o_ready = (count_q != (PW+1)'(DEPTH));
  assign o_valid = (count_q != '0);
  assign o_data = mem_q[rd_ptr_q];

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= i_data;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : lfs_skid_fifo

`default_nettype wire

// File: testbench/pcs_model.sv
`timescale 1ns/10ps
`default_nettype none

module pcs_model
  import lfs_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Columns from the block
  input wire col_t i_col,
  input wire logic i_valid,
  input wire logic i_stall,
  output logic o_ready,
  // Columns toward the block
  output col_t o_rx_col,
  output logic o_rx_valid
);
  col_t got[$];

  initial
  begin
    o_ready = 1'h0;
    o_rx_col = '0;
    o_rx_valid = 1'h0;
  end

  // Capture taken columns, ready lags the stall by a cycle
  always @(posedge i_clk)
  begin
    if (i_valid && o_ready)
    begin
      got.push_back(i_col);
    end
    o_ready <= !i_stall;
  end

  // Received stream, inverted value once released
  task send(input col_t c, input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      o_rx_col <= c;
      o_rx_valid <= 1'h1;
    end
    @(posedge i_clk);
    o_rx_valid <= 1'h0;
    o_rx_col <= ~c;
  endtask : send

endmodule : pcs_model

`default_nettype wire

// File: testbench/link_fault_signaling_rs_tb.sv
`timescale 1ns/10ps
`default_nettype none

module link_fault_signaling_rs_tb
  import lfs_pkg::*;
;
  typedef struct packed {
    logic wr;
    logic [15:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic [1:0] en;
  } row_t;

  localparam col_t LF_COL = '{data: {32'h07070707, CODE_LOCAL, 16'h0000, SEQ_CHAR},
    ctrl: {4'hf, SEQ_CTRL}};
  localparam col_t RF_COL = '{data: {32'h07070707, CODE_REMOTE, 16'h0000, SEQ_CHAR},
    ctrl: {4'hf, SEQ_CTRL}};
  localparam col_t FRM = '{data: 64'h0123456789abcdef, ctrl: 8'h00};
  localparam col_t FRM2 = '{data: 64'hfedcba9876543210, ctrl: 8'h00};
  localparam col_t HI_LF = '{data: {CODE_LOCAL, 16'h0000, SEQ_CHAR, 32'h07070707},
    ctrl: {SEQ_CTRL, 4'hf}};

  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [15:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic wr = 1'h0;
  logic rd = 1'h0;
  col_t rx_col;
  col_t tx_col = '0;
  col_t pcs_col;
  logic rx_v;
  logic tx_v = 1'h0;
  logic tx_rdy;
  logic pcs_v;
  logic pcs_rdy;
  logic stall = 1'h0;
  logic lf;
  logic rf;
  logic ue;
  logic ge;
  logic lf_off;
  logic rf_off;
  logic ue_off;
  logic ge_off;
  int bad_count = 0;
  int n_checks = 0;
  row_t rows[5] = '{
    '{1'h0, CFG_ADDR, 32'h0, 32'h0, 2'h0},
    '{1'h1, CFG_ADDR, 32'h3, 32'h3, 2'h3},
    '{1'h1, CFG_ADDR, 32'hfffffffd, 32'h1, 2'h1},
    '{1'h1, 16'h0000, 32'h3, 32'h0, 2'h1},
    '{1'h1, CFG_ADDR, 32'h0, 32'h0, 2'h0}
  };

  always #25 clk = ~clk;

  link_fault_signaling_rs link_fault_signaling_rs_inst (
    .I_CORE_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_RX_COL(rx_col),
    .I_RX_VALID(rx_v), .I_TX_COL(tx_col), .I_TX_VALID(tx_v), .O_TX_READY(tx_rdy),
    .O_PCS_COL(pcs_col), .O_PCS_VALID(pcs_v), .I_PCS_READY(pcs_rdy),
    .O_LOCAL_FAULT(lf), .O_REMOTE_FAULT(rf), .O_UNIDIR_EN(ue), .O_FAULT_GEN_EN(ge)
  );

  link_fault_signaling_rs #(.LF_GEN_EN(1'b0)) link_fault_signaling_rs_off_inst (
    .I_CORE_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(), .I_RX_COL(rx_col),
    .I_RX_VALID(rx_v), .I_TX_COL(tx_col), .I_TX_VALID(tx_v), .O_TX_READY(),
    .O_PCS_COL(), .O_PCS_VALID(), .I_PCS_READY(pcs_rdy),
    .O_LOCAL_FAULT(lf_off), .O_REMOTE_FAULT(rf_off), .O_UNIDIR_EN(ue_off),
    .O_FAULT_GEN_EN(ge_off)
  );

  pcs_model pcs_model_inst (
    .i_clk(clk), .i_col(pcs_col), .i_valid(pcs_v), .i_stall(stall),
    .o_ready(pcs_rdy), .o_rx_col(rx_col), .o_rx_valid(rx_v)
  );

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task check(input logic [71:0] seen, input logic [71:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task reg_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : reg_wr

  task reg_rd(input logic [15:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    rv = rdata;
  endtask : reg_rd

  task tx_put(input col_t c);
    int k;
    @(posedge clk);
    tx_col <= c;
    tx_v <= 1'h1;
    k = 0;
    @(posedge clk);
    while (!tx_rdy && k < 50)
    begin
      k++;
      @(posedge clk);
    end
    tx_v <= 1'h0;
    if (!tx_rdy)
    begin
      bad_count++;
      final_report();
    end
  endtask : tx_put

  task expect_col(input col_t e);
    int k;
    k = 0;
    while (pcs_model_inst.got.size() == 0 && k < 50)
    begin
      k++;
      @(posedge clk);
    end
    if (pcs_model_inst.got.size() == 0)
    begin
      bad_count++;
      final_report();
    end
    check(72'(pcs_model_inst.got.pop_front()), 72'(e));
  endtask : expect_col

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        reg_wr(rows[i].a, rows[i].d);
      reg_rd(rows[i].a);
      check(72'(rv), 72'(rows[i].r));
      check(72'({ue, ge}), 72'(rows[i].en));
    end
    // Stalled far side: two columns held, third refused
    @(posedge clk);
    stall <= 1'h1;
    tx_put(FRM);
    tx_put(FRM2);
    @(negedge clk);
    check(72'(tx_rdy), 72'h0);
    @(posedge clk);
    stall <= 1'h0;
    expect_col(FRM);
    expect_col(FRM2);
    // Local fault with signaling off
    pcs_model_inst.send(LF_COL, 3);
    @(negedge clk);
    check(72'({lf, rf}), 72'h2);
    reg_rd(STAT_ADDR);
    check(72'(rv[5:4]), 72'h0);
    pcs_model_inst.send(LF_COL, 1);
    reg_rd(STAT_ADDR);
    check(72'(rv[5:4]), 72'h1);
    tx_put(IDLE_COL);
    expect_col(IDLE_COL);
    // One-way mode, then bidirectional mode
    reg_wr(CFG_ADDR, 32'h3);
    tx_put(FRM);
    expect_col(FRM);
    tx_put(IDLE_COL);
    expect_col(REMOTE_COL);
    reg_wr(CFG_ADDR, 32'h1);
    tx_put(FRM);
    expect_col(REMOTE_COL);
    // Clearing window
    pcs_model_inst.send(IDLE_COL, 127);
    @(negedge clk);
    check(72'(lf), 72'h1);
    reg_rd(STAT_ADDR);
    check(72'(rv[5:4]), 72'h1);
    pcs_model_inst.send(IDLE_COL, 1);
    @(negedge clk);
    check(72'(lf), 72'h0);
    reg_rd(STAT_ADDR);
    check(72'(rv[5:4]), 72'h0);
    // Remote fault
    pcs_model_inst.send(RF_COL, 4);
    @(negedge clk);
    check(72'({lf, rf}), 72'h1);
    reg_rd(STAT_ADDR);
    check(72'(rv[5:4]), 72'h2);
    tx_put(FRM);
    expect_col(IDLE_COL);
    // High-half local set breaks the remote run
    pcs_model_inst.send(HI_LF, 1);
    @(negedge clk);
    check(72'({lf, rf}), 72'h3);
    pcs_model_inst.send(RF_COL, 3);
    reg_rd(STAT_ADDR);
    check(72'(rv[5:2]), 72'h9);
    pcs_model_inst.send(RF_COL, 1);
    reg_rd(STAT_ADDR);
    check(72'(rv[5:2]), 72'ha);
    // Mode 10 leaves frames alone
    reg_wr(CFG_ADDR, 32'h2);
    tx_put(FRM);
    expect_col(FRM);
    check(72'({ue, ge}), 72'h2);
    check(72'({lf_off, rf_off, ue_off, ge_off}), 72'h0);
    // Reset in mid-run
    @(posedge clk);
    rst <= 1'h1;
    @(negedge clk);
    check(72'({lf, rf, ue, ge, pcs_v, tx_rdy}), 72'h1);
    @(posedge clk);
    rst <= 1'h0;
    reg_rd(CFG_ADDR);
    check(72'(rv), 72'h0);
    final_report();
  end

endmodule : link_fault_signaling_rs_tb

`default_nettype wire
